/* src/alu_ops_pkg.sv */
// Constants, types and carriers for the carry add, AND and arithmetic shift datapath.
// Assumes a single-port data memory that answers a read one cycle after the request.
package alu_ops_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_REGS = 16;
  localparam logic [4:0] STATUS_IDX = 5'h10;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [3:0] DEFAULT_WORK_IDX = 4'h0;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam int unsigned SR_C = 0;
  localparam int unsigned SR_Z = 1;
  localparam int unsigned SR_OV = 2;
  localparam int unsigned SR_N = 3;
  localparam int unsigned SR_DC = 8;

  typedef enum logic [3:0] {
    op_add_with_carry_op_rr = 4'h0, op_add_with_carry_op_lit = 4'h1, op_add_with_carry_op_f = 4'h2, op_add_with_carry_op_slit = 4'h3,
    op_and_rr = 4'h4, op_and_lit = 4'h5, op_and_f = 4'h6, op_and_slit = 4'h7,
    op_asr_f = 4'h8, op_asr_w = 4'h9
  } op_t;

  typedef enum logic [2:0] {
    am_direct = 3'h0, am_ind = 3'h1, am_post_dec = 3'h2,
    am_post_inc = 3'h3, am_pre_dec = 3'h4, am_pre_inc = 3'h5
  } amode_t;

  typedef enum logic [1:0] {
    st_idle = 2'h0, st_rd = 2'h1, st_wt = 2'h3, st_ex = 2'h2
  } state_t;

  typedef struct packed {
    op_t op;
    logic byte_mode;
    logic dest_file;
    logic [3:0] base_idx;
    logic [3:0] src_idx;
    logic [3:0] dst_idx;
    amode_t src_mode;
    amode_t dst_mode;
    logic [9:0] lit;
    logic [12:0] faddr;
  } cmd_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic byte_mode;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;
endpackage : alu_ops_pkg

/* src/carry_add_and_shift_ops.sv */
// Execution datapath for add with carry, AND and arithmetic shift right, with its own register file.
// Assumes the decoder holds cmd steady while cmd_valid is high and memory reads return one cycle late.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/100ps
module carry_add_and_shift_ops
  import alu_ops_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  output logic cmd_ready,
  output logic done,
  output mem_req_t mem_req,
  input wire logic [15:0] mem_rdata,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [15:0] status
);
  state_t st_q, st_d;
  cmd_t cmd_q, cmd_d;
  logic [15:0] opb_q, opb_d;
  logic [15:0] regs_q [NUM_REGS];
  logic [15:0] regs_d [NUM_REGS];
  logic [15:0] status_q, status_d;
  mem_req_t mem_q, mem_d;
  logic done_q, done_d;
  logic ready_q, ready_d;
  logic [15:0] rdata_q, rdata_d;

  logic is_add, is_and, is_asr, uses_ws, uses_wd, is_file, is_lit;
  logic in_uses_ws, in_is_file, in_needs_mem;
  logic [15:0] step, in_step, opa, res, src_ptr;
  logic [16:0] sum17;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic zero, carry, neg, ovf, dcar, dst_is_mem;
  logic [3:0] dst_reg;
  logic [15:0] dst_addr;

  function automatic logic [15:0] eff_addr(amode_t m, logic [15:0] p, logic [15:0] s);
    if (m == am_pre_dec) return p - s;
    if (m == am_pre_inc) return p + s;
    return p;
  endfunction : eff_addr

  function automatic logic [15:0] upd_ptr(amode_t m, logic [15:0] p, logic [15:0] s);
    if (m == am_post_dec || m == am_pre_dec) return p - s;
    if (m == am_post_inc || m == am_pre_inc) return p + s;
    return p;
  endfunction : upd_ptr

  // Decode of the incoming command
  always_comb begin
    in_uses_ws = (cmd.op == op_add_with_carry_op_rr) || (cmd.op == op_and_rr) || (cmd.op == op_asr_w);
    in_is_file = (cmd.op == op_add_with_carry_op_f) || (cmd.op == op_and_f) || (cmd.op == op_asr_f);
    in_needs_mem = in_is_file || (in_uses_ws && cmd.src_mode != am_direct);
    in_step = cmd.byte_mode ? BYTE_STEP : WORD_STEP;
  end

  // Datapath on the latched command
  always_comb begin
    is_add = 1'b0;
    is_and = 1'b0;
    is_asr = 1'b0;
    unique case (cmd_q.op)
      op_add_with_carry_op_rr, op_add_with_carry_op_lit, op_add_with_carry_op_f, op_add_with_carry_op_slit: is_add = 1'b1;
      op_and_rr, op_and_lit, op_and_f, op_and_slit: is_and = 1'b1;
      op_asr_f, op_asr_w: is_asr = 1'b1;
      default: is_and = 1'b0;
    endcase
    uses_ws = (cmd_q.op == op_add_with_carry_op_rr) || (cmd_q.op == op_and_rr) || (cmd_q.op == op_asr_w);
    uses_wd = uses_ws || (cmd_q.op == op_add_with_carry_op_slit) || (cmd_q.op == op_and_slit);
    is_file = (cmd_q.op == op_add_with_carry_op_f) || (cmd_q.op == op_and_f) || (cmd_q.op == op_asr_f);
    is_lit = (cmd_q.op == op_add_with_carry_op_lit) || (cmd_q.op == op_and_lit);
    step = cmd_q.byte_mode ? BYTE_STEP : WORD_STEP;
    src_ptr = regs_q[cmd_q.src_idx];
    if (is_file) opa = regs_q[DEFAULT_WORK_IDX];
    else if (is_lit) opa = regs_q[cmd_q.dst_idx];
    else opa = regs_q[cmd_q.base_idx];
    sum17 = {1'b0, opa} + {1'b0, opb_q} + {16'h0000, status_q[SR_C]};
    sum9 = {1'b0, opa[7:0]} + {1'b0, opb_q[7:0]} + {8'h00, status_q[SR_C]};
    sum5 = {1'b0, opa[3:0]} + {1'b0, opb_q[3:0]} + {4'h0, status_q[SR_C]};
    if (is_add) res = cmd_q.byte_mode ? {8'h00, sum9[7:0]} : sum17[15:0];
    else if (is_and) res = cmd_q.byte_mode ? {8'h00, opa[7:0] & opb_q[7:0]} : opa & opb_q;
    else res = cmd_q.byte_mode ? {8'h00, opb_q[7], opb_q[7:1]} : {opb_q[15], opb_q[15:1]};
    zero = cmd_q.byte_mode ? (res[7:0] == 8'h00) : (res == 16'h0000);
    neg = cmd_q.byte_mode ? res[7] : res[15];
    carry = is_asr ? opb_q[0] : (cmd_q.byte_mode ? sum9[8] : sum17[16]);
    dcar = cmd_q.byte_mode ? sum5[4] : sum9[8];
    ovf = cmd_q.byte_mode ? ((opa[7] == opb_q[7]) && (res[7] != opa[7]))
                          : ((opa[15] == opb_q[15]) && (res[15] != opa[15]));
    dst_is_mem = is_file ? cmd_q.dest_file : (uses_wd && cmd_q.dst_mode != am_direct);
    dst_addr = is_file ? {3'b000, cmd_q.faddr}
                       : eff_addr(cmd_q.dst_mode, regs_q[cmd_q.dst_idx], step);
    dst_reg = (is_file && !cmd_q.dest_file) ? DEFAULT_WORK_IDX : cmd_q.dst_idx;
  end

  // Sequencing, register port and write-back
  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    opb_d = opb_q;
    regs_d = regs_q;
    status_d = status_q;
    mem_d = '0;
    done_d = 1'b0;
    rdata_d = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == STATUS_IDX) rdata_d = status_q;
      else if (!reg_addr[4]) rdata_d = regs_q[reg_addr[3:0]];
    end
    // Software writes land first so a retiring instruction overrides them in the same cycle
    if (reg_wr) begin
      if (reg_addr == STATUS_IDX) status_d = reg_wdata;
      else if (!reg_addr[4]) regs_d[reg_addr[3:0]] = reg_wdata;
    end
    unique case (st_q)
      st_idle: begin
        if (cmd_valid) begin
          cmd_d = cmd;
          if (in_needs_mem) begin
            mem_d.rd = 1'b1;
            mem_d.byte_mode = cmd.byte_mode;
            mem_d.addr = in_is_file ? {3'b000, cmd.faddr}
                                    : eff_addr(cmd.src_mode, regs_q[cmd.src_idx], in_step);
            st_d = st_rd;
          end else begin
            if (in_uses_ws) opb_d = regs_q[cmd.src_idx];
            else if (cmd.op == op_add_with_carry_op_slit || cmd.op == op_and_slit) opb_d = {11'h000, cmd.lit[4:0]};
            else opb_d = {6'h00, cmd.lit};
            st_d = st_ex;
          end
        end
      end
      st_rd: st_d = st_wt;
      st_wt: begin
        opb_d = cmd_q.byte_mode ? {8'h00, mem_rdata[7:0]} : mem_rdata;
        st_d = st_ex;
      end
      st_ex: begin
        if (uses_ws) regs_d[cmd_q.src_idx] = upd_ptr(cmd_q.src_mode, src_ptr, step);
        if (uses_wd) regs_d[cmd_q.dst_idx] = upd_ptr(cmd_q.dst_mode, regs_q[cmd_q.dst_idx], step);
        if (dst_is_mem) begin
          mem_d.wr = 1'b1;
          mem_d.byte_mode = cmd_q.byte_mode;
          mem_d.addr = dst_addr;
          mem_d.wdata = res;
        end else if (cmd_q.byte_mode) begin
          regs_d[dst_reg] = {regs_d[dst_reg][15:8], res[7:0]};
        end else begin
          regs_d[dst_reg] = res;
        end
        status_d[SR_N] = neg;
        if (is_add) begin
          status_d[SR_Z] = status_q[SR_Z] & zero;
          status_d[SR_C] = carry;
          status_d[SR_OV] = ovf;
          status_d[SR_DC] = dcar;
        end else begin
          status_d[SR_Z] = zero;
          if (is_asr) status_d[SR_C] = carry;
        end
        done_d = 1'b1;
        st_d = st_idle;
      end
    endcase
    ready_d = (st_d == st_idle);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= st_idle;
      cmd_q <= '0;
      opb_q <= 16'h0000;
      regs_q <= '{default: REG_RST};
      status_q <= STATUS_RST;
      mem_q <= '0;
      done_q <= 1'b0;
      ready_q <= 1'b1;
      rdata_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      opb_q <= opb_d;
      regs_q <= regs_d;
      status_q <= status_d;
      mem_q <= mem_d;
      done_q <= done_d;
      ready_q <= ready_d;
      rdata_q <= rdata_d;
    end
  end

  assign cmd_ready = ready_q;
  assign done = done_q;
  assign mem_req = mem_q;
  assign reg_rdata = rdata_q;
  assign status = status_q;

  sequence s_fetch;
    st_q == st_rd ##1 st_q == st_wt ##1 st_q == st_ex;
  endsequence

  property p_fetch_path;
    @(posedge clock) disable iff (rst) (st_q == st_idle && cmd_valid && in_needs_mem) |=> s_fetch;
  endproperty
  a_fetch_path: assert property (p_fetch_path) else $error("Memory operand fetch did not take three steps");

  property p_add_sum;
    @(posedge clock) disable iff (rst) (st_q == st_ex && is_add && !cmd_q.byte_mode)
      |-> res == 16'(opa + opb_q + {15'h0000, status_q[SR_C]});
  endproperty
  a_add_sum: assert property (p_add_sum) else $error("Add with carry result wrong");

  property p_ind_dest;
    @(posedge clock) disable iff (rst) (st_q == st_ex && uses_wd && cmd_q.dst_mode == am_ind)
      |=> mem_q.wr && mem_q.addr == $past(regs_q[cmd_q.dst_idx]) && mem_q.wdata == $past(res);
  endproperty
  a_ind_dest: assert property (p_ind_dest) else $error("Indirect destination not written to memory");

  property p_asr_byte;
    @(posedge clock) disable iff (rst) (st_q == st_ex && cmd_q.op == op_asr_w && cmd_q.byte_mode
      && cmd_q.dst_mode != am_direct) |=> mem_q.wr && mem_q.byte_mode
      && mem_q.wdata[7:0] == {$past(opb_q[7]), $past(opb_q[7:1])};
  endproperty
  a_asr_byte: assert property (p_asr_byte) else $error("Byte shift to pointer wrong");

  property p_post_inc;
    @(posedge clock) disable iff (rst) (st_q == st_ex && uses_ws && cmd_q.src_mode == am_post_inc
      && cmd_q.src_idx != cmd_q.dst_idx && dst_is_mem && !reg_wr)
      |=> regs_q[$past(cmd_q.src_idx)] == $past(src_ptr) + $past(step);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("Source pointer not advanced by step");

  property p_asr_flags;
    @(posedge clock) disable iff (rst) (st_q == st_ex && is_asr && !reg_wr)
      |=> status_q[SR_C] == $past(opb_q[0]) && status_q[SR_N] == $past(neg);
  endproperty
  a_asr_flags: assert property (p_asr_flags) else $error("Shift flags wrong");

  property p_byte_keep;
    @(posedge clock) disable iff (rst) (st_q == st_ex && cmd_q.byte_mode && !dst_is_mem && !reg_wr
      && !(uses_ws && dst_reg == cmd_q.src_idx)) |=> regs_q[$past(dst_reg)][15:8] == $past(regs_q[dst_reg][15:8]);
  endproperty
  a_byte_keep: assert property (p_byte_keep) else $error("Byte write disturbed upper byte");

  property p_file_w0;
    @(posedge clock) disable iff (rst) (st_q == st_ex && is_file && !cmd_q.dest_file && !cmd_q.byte_mode)
      |=> !mem_q.wr && regs_q[0] == $past(res);
  endproperty
  a_file_w0: assert property (p_file_w0) else $error("File form did not write W0");

  property p_z_sticky;
    @(posedge clock) disable iff (rst) (st_q == st_ex && is_add && !status_q[SR_Z] && !reg_wr)
      |=> !status_q[SR_Z];
  endproperty
  a_z_sticky: assert property (p_z_sticky) else $error("Add with carry set zero flag");
endmodule : carry_add_and_shift_ops

/* dv/carry_add_and_shift_ops_tb.sv */
// Self-checking bench for the carry add and shift datapath.
// Assumes the bench plays memory, answering a read one cycle after the request.
`timescale 1ns/100ps
module carry_add_and_shift_ops_tb;
  import alu_ops_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  cmd_t cmd = '0;
  logic cmd_ready, done, wr_seen, wr_byte, by, fl, an;
  op_t o;
  cmd_t cm;
  amode_t dm;
  logic [15:0] a, x, k;
  mem_req_t mem_req;
  logic [15:0] mem_rdata = 16'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic [15:0] mem_word = 16'h0;
  logic [15:0] reg_rdata, status, wr_addr, wr_data, rd_addr, b, s, v, p, q, m, st;
  logic [4:0] reg_addr = 5'h0;
  logic [16:0] sum;
  integer seed = 32'h8d174459;
  integer bad_count = 0;
  integer tests_run = 0;
  integer i, n;

  carry_add_and_shift_ops dut (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .done(done), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .status(status));

  always #10 clock = ~clock;

  // Unread cycles show inverted data so stale values never pass
  always @(posedge clock) begin
    mem_rdata <= mem_req.rd ? mem_word : ~mem_rdata;
    if (mem_req.rd) rd_addr <= mem_req.addr;
    if (mem_req.wr) begin
      wr_seen <= 1'b1;
      wr_byte <= mem_req.byte_mode;
      wr_addr <= mem_req.addr;
      wr_data <= mem_req.wdata;
    end else if (cmd_valid && cmd_ready) begin
      wr_seen <= 1'b0;
    end
  end

  task chk(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (e !== g) begin
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
      bad_count++;
    end
  endtask : chk

  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] k);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(e & k, reg_rdata & k);
  endtask : rd

  task exec(input cmd_t c, input integer lat);
    @(posedge clock);
    cmd <= c;
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (n == 1) chk(16'h0000, {15'h0, cmd_ready});
    end while (done !== 1'b1 && n < 20);
    chk(16'(lat), 16'(n));
    chk(16'h0001, {15'h0, cmd_ready});
  endtask : exec

  function automatic cmd_t mk(op_t o, logic by, logic df, logic [3:0] bi, logic [3:0] si,
    logic [3:0] di, amode_t sm, amode_t dm, logic [12:0] fa);
    cmd_t c;
    c = '0;
    c.op = o;
    c.byte_mode = by;
    c.dest_file = df;
    c.base_idx = bi;
    c.src_idx = si;
    c.dst_idx = di;
    c.src_mode = sm;
    c.dst_mode = dm;
    c.faddr = fa;
    return c;
  endfunction : mk

  // Result in the low 16 bits, carry out in bit 16
  function automatic logic [16:0] model(op_t o, logic by, logic [15:0] a, logic [15:0] x, logic c);
    logic [16:0] r;
    logic [8:0] t;
    t = {1'b0, a[7:0]} + {1'b0, x[7:0]} + {8'h00, c};
    r = {1'b0, a} + {1'b0, x} + {16'h0000, c};
    if (by) r = {t[8], 8'h00, t[7:0]};
    if (o >= op_and_rr && o <= op_and_slit) r = {1'b0, a & x};
    if (o == op_asr_f || o == op_asr_w) r = by ? {x[0], 8'h00, x[7], x[7:1]} : {x[0], x[15], x[15:1]};
    return r;
  endfunction : model

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    bad_count++;
    tally_and_finish;
  end

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd(5'h05, 16'h0, 16'hffff);
    rd(5'h10, 16'h0, 16'hffff);
    rd(5'h1f, 16'h0, 16'hffff);
    for (i = 0; i < 8; i++) begin
      b = 16'($random(seed));
      s = 16'($random(seed));
      v = 16'($random(seed));
      q = 16'($random(seed));
      if (i < 2) begin
        b = i ? 16'h00ff : 16'hffff;
        s = 16'h0;
        q = i ? 16'h0001 : 16'h0003;
      end
      wr(5'h01, b);
      wr(5'h02, s);
      wr(5'h03, v);
      wr(5'h10, {14'h0, q[1:0]});
      exec(mk(op_add_with_carry_op_rr, i[0], 1'b0, 4'h1, 4'h2, 4'h3, am_direct, am_direct, 13'h0), 2);
      sum = i[0] ? {9'h0, b[7:0]} + s[7:0] + q[0] : {1'b0, b} + s + q[0];
      rd(5'h03, i[0] ? {v[15:8], sum[7:0]} : sum[15:0], 16'hffff);
      st = {14'h0, q[1] & ((i[0] ? sum[7:0] : sum[15:0]) == 0), i[0] ? sum[8] : sum[16]};
      rd(5'h10, st, 16'h0003);
      chk(st, status & 16'h0003);
    end
    $display("add with carry test done");
    for (i = 0; i < 3; i++) begin
      b = 16'($random(seed));
      s = 16'($random(seed));
      p = 16'h0800 + (16'($random(seed)) & 16'h07fe);
      dm = (i == 2) ? am_ind : am_post_inc;
      m = i[0] ? 16'h00ff : 16'hffff;
      wr(5'h01, b);
      wr(5'h02, s);
      wr(5'h04, p);
      wr(5'h10, 16'h0);
      exec(mk(op_add_with_carry_op_rr, i[0], 1'b0, 4'h1, 4'h2, 4'h4, am_direct, dm, 13'h0), 2);
      sum = {1'b0, b} + s;
      rd(5'h04, p + ((i == 2) ? 16'h0000 : (i[0] ? BYTE_STEP : WORD_STEP)), 16'hffff);
      chk(16'h1, {15'h0, wr_seen});
      chk(p, wr_addr);
      chk(sum[15:0] & m, wr_data & m);
      chk({15'h0, i[0]}, {15'h0, wr_byte});
    end
    $display("indirect destination test done");
    for (i = 0; i < 8; i++) begin
      v = (i < 2) ? 16'h0001 : 16'($random(seed));
      p = 16'h1000 + (16'($random(seed)) & 16'h00fe);
      q = 16'h2000 + (16'($random(seed)) & 16'h00fe);
      m = i[0] ? 16'h00ff : 16'hffff;
      s = i[0] ? BYTE_STEP : WORD_STEP;
      // Walk all four modify modes so pre and post, up and down are each reached
      dm = amode_t'(3'(i[2:1]) + 3'h2);
      if (dm == am_post_dec || dm == am_pre_dec) s = 16'h0000 - s;
      mem_word = v;
      wr(5'h05, p);
      wr(5'h06, q);
      wr(5'h10, 16'h0);
      exec(mk(op_asr_w, i[0], 1'b0, 4'h0, 4'h5, 4'h6, dm, dm, 13'h0), 4);
      b = i[0] ? {8'h0, v[7], v[7:1]} : {v[15], v[15:1]};
      rd(5'h05, p + s, 16'hffff);
      rd(5'h06, q + s, 16'hffff);
      chk((dm >= am_pre_dec) ? p + s : p, rd_addr);
      chk((dm >= am_pre_dec) ? q + s : q, wr_addr);
      chk(b & m, wr_data & m);
      st = {12'h0, i[0] ? v[7] : v[15], 1'b0, (b & m) == 0, v[0]};
      rd(5'h10, st, 16'h000b);
    end
    $display("shift test done");
    for (i = 0; i < 2; i++) begin
      b = 16'($random(seed));
      v = 16'($random(seed));
      p = 16'($random(seed)) & 16'h1ffe;
      mem_word = v;
      wr(5'h00, b);
      wr(5'h10, 16'h0);
      exec(mk(op_add_with_carry_op_f, 1'b0, i[0], 4'h0, 4'h0, 4'h0, am_direct, am_direct, p[12:0]), 4);
      sum = {1'b0, b} + v;
      rd(5'h00, i[0] ? b : sum[15:0], 16'hffff);
      chk(p, rd_addr);
      chk({15'h0, i[0]}, {15'h0, wr_seen});
      if (i[0]) begin
        chk(p, wr_addr);
        chk(sum[15:0], wr_data);
      end
    end
    $display("file form test done");
    // every form in word then byte width
    for (i = 0; i < 20; i++) begin
      o = op_t'(4'(i % 10));
      by = (i >= 10);
      b = 16'($random(seed));
      s = 16'($random(seed));
      v = 16'($random(seed));
      m = 16'($random(seed));
      q = 16'($random(seed));
      mem_word = 16'($random(seed));
      k = by ? 16'h00ff : 16'hffff;
      fl = (o == op_add_with_carry_op_f) || (o == op_and_f) || (o == op_asr_f);
      an = (o >= op_and_rr) && (o <= op_and_slit);
      wr(5'h00, m);
      wr(5'h01, b);
      wr(5'h02, s);
      wr(5'h03, v);
      wr(5'h10, {14'h0, 1'b1, q[15]});
      cm = mk(o, by, q[14], 4'h1, 4'h2, 4'h3, am_direct, am_direct, {q[12:1], 1'b0});
      cm.lit = q[9:0];
      exec(cm, fl ? 4 : 2);
      a = fl ? m : b;
      x = fl ? mem_word : s;
      if (o == op_add_with_carry_op_lit || o == op_and_lit) begin
        a = v;
        x = {6'h00, q[9:0]};
      end
      if (o == op_add_with_carry_op_slit || o == op_and_slit) x = {11'h000, q[4:0]};
      sum = model(o, by, a, x, q[15]);
      if (!fl) begin
        rd(5'h03, by ? {v[15:8], sum[7:0]} : sum[15:0], 16'hffff);
      end else if (!q[14]) begin
        rd(5'h00, by ? {m[15:8], sum[7:0]} : sum[15:0], 16'hffff);
        chk(16'h0000, {15'h0, wr_seen});
        chk({3'h0, q[12:1], 1'b0}, rd_addr);
      end else begin
        rd(5'h00, m, 16'hffff);
        chk(16'h0001, {15'h0, wr_seen});
        chk({3'h0, q[12:1], 1'b0}, rd_addr);
        chk({3'h0, q[12:1], 1'b0}, wr_addr);
        chk(sum[15:0] & k, wr_data & k);
      end
      st = {12'h0, by ? sum[7] : sum[15], 1'b0, (sum[15:0] & k) == 16'h0000, an ? q[15] : sum[16]};
      chk(st, status & 16'h000b);
    end
    $display("all forms test done");
    tally_and_finish;
  end
endmodule : carry_add_and_shift_ops_tb
